// file: inc/sop_array_pkg.sv
// Purpose: shared constants and types for the sum-of-products logic array
// Assumes: 32-bit APB register bus, byte addresses
// Notes:   array line 2k is input k true, line 2k+1 its complement
package sop_array_pkg;

    localparam int N_IN      = 20;             // array inputs
    localparam int N_LINE    = 2 * N_IN;       // true and complement lines
    localparam int N_TERM    = 64;             // product terms
    localparam int N_MC      = 8;              // output macrocells
    localparam int GRP       = N_TERM / N_MC;  // terms per macrocell group
    localparam int N_CELL    = N_LINE * N_TERM;
    localparam int N_DED     = 10;             // plain dedicated inputs
    localparam int SLOT_CLK  = N_DED;          // array slot of clock-capable pin
    localparam int SLOT_OE   = N_DED + 1;      // array slot of enable-capable pin
    localparam int SLOT_FB   = N_DED + 2;      // first macrocell feedback slot
    localparam int N_PIN_IN  = N_DED + 2 + N_MC;
    localparam int ADDR_W    = 12;
    localparam int HI_W      = N_LINE - 32;    // bits in second word of a term

    // register byte offsets
    localparam logic [ADDR_W-1:0] ARR_BASE   = 12'h000; // 2 words per term
    localparam logic [ADDR_W-1:0] CTRL_ADDR  = 12'h200;
    localparam logic [ADDR_W-1:0] CFG_ADDR   = 12'h204;
    localparam logic [ADDR_W-1:0] STAT_ADDR  = 12'h208;

    // field positions
    localparam int CTRL_RUN     = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_MODE_HI = 2;
    localparam int CFG_FN_LO    = 0;
    localparam int CFG_POL_LO   = 8;
    localparam int STAT_Q_LO    = 0;
    localparam int STAT_PIN_LO  = 8;
    localparam int STAT_OE_LO   = 16;

    typedef enum logic [1:0] {
        MODE_SIMPLE,
        MODE_REG,
        MODE_TRI
    } mode_t;

    typedef struct packed {
        logic [N_MC-1:0] act_low; // 1: function inverted
        logic [N_MC-1:0] fn;      // simple: 1 output, 0 input; reg: 1 register, 0 i/o
    } mc_cfg_t;

    localparam mc_cfg_t     CFG_RST  = '0;
    localparam logic [N_MC-1:0] OUT_RST = 8'hFF;
    localparam logic [N_LINE-1:0] CELL_RST = 40'h00_0000_0000;
    localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

endpackage

// file: src/sop_logic_array.sv
// Purpose: programmable AND array, fixed OR groups and eight output macrocells
// Assumes: all pin inputs asynchronous to clk; configured over APB while stopped
// Notes:   pin outputs are registered, one cycle behind the array
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - 20 input pairs cross 64 product terms, one cell per crossing, 2560 cells.
// - term true only while every connected line is high; unconnected lines ignored.
// - 64 terms in eight groups of eight; seven or eight ORed per output.
// - first term of a group acts as three-state enable where needed.
// - registered macrocell captures function on rising edge of clock pin.
// - polarity programmable per output, applied before the register.
// - three global modes: simple, registered, three-state combinational.
// - outside registered mode clock and enable pins are plain array inputs.
// - registered mode: common clock pin, shared enable for registered outputs.
// - simple and registered modes: each macrocell picks one of two functions.
// - three-state mode fixed: outer cells three-state outputs, six bidirectional.
// - registered macrocell feeds its register state back into the array.
// - simple mode output drives continuously, no three-state control.
// - bidirectional macrocell drives under term enable and returns pin level.
// - input-only macrocell never drives, only supplies pin level.
// - every macrocell register cleared to zero at reset.
// - after reset registered pins show high when enabled, any polarity.
// - inputs not connected to a term never affect its output.
// - shared registered output enable is active low.
module sop_logic_array (
    input  wire logic                              clk,       // 40 MHz system clock
    input  wire logic                              rst_b,     // async reset, active low
    input  wire logic                              ce,        // clock enable, freezes state
    input  wire logic                              psel,      // apb select
    input  wire logic                              penable,   // apb access phase
    input  wire logic                              pwrite,    // apb write
    input  wire logic [sop_array_pkg::ADDR_W-1:0]  paddr,     // apb byte address
    input  wire logic [31:0]                       pwdata,    // apb write data
    output logic      [31:0]                       prdata,    // apb read data
    output logic                                   pready,    // apb ready
    output logic                                   pslverr,   // apb error
    input  wire logic [sop_array_pkg::N_DED-1:0]   din_pin,   // dedicated input pins
    input  wire logic                              clk_pin,   // clock-capable pin
    input  wire logic                              oe_pin_b,  // enable-capable pin
    input  wire logic [sop_array_pkg::N_MC-1:0]    io_in,     // macrocell pin level
    output logic      [sop_array_pkg::N_MC-1:0]    io_out,    // macrocell pin drive value
    output logic      [sop_array_pkg::N_MC-1:0]    io_oe      // macrocell pin drive enable
);

    localparam int NI = sop_array_pkg::N_IN;
    localparam int NL = sop_array_pkg::N_LINE;
    localparam int NT = sop_array_pkg::N_TERM;
    localparam int NM = sop_array_pkg::N_MC;
    localparam int G  = sop_array_pkg::GRP;
    localparam int NP = sop_array_pkg::N_PIN_IN;
    localparam int HW = sop_array_pkg::HI_W;

    if (NL * NT != sop_array_pkg::N_CELL || NM * G != NT || HW < 1 || HW > 32) begin : g_chk
        $error("array dimensions cannot be served");
    end

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [NP-1:0] pin_raw;
    logic [NP-1:0] pin_m_q;
    logic [NP-1:0] pin_s_q;
    logic          clk_prev_q;

    assign pin_raw = {io_in, oe_pin_b, clk_pin, din_pin};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_m_q    <= '0;
            pin_s_q    <= '0;
            clk_prev_q <= 1'b0;
        end else if (ce) begin
            pin_m_q    <= pin_raw;
            pin_s_q    <= pin_m_q;
            clk_prev_q <= pin_s_q[sop_array_pkg::SLOT_CLK];
        end
    end

    wire logic [sop_array_pkg::N_DED-1:0] din_s  = pin_s_q[sop_array_pkg::N_DED-1:0];
    wire logic                            clk_s  = pin_s_q[sop_array_pkg::SLOT_CLK];
    wire logic                            oe_s_b = pin_s_q[sop_array_pkg::SLOT_OE];
    wire logic [NM-1:0]                   io_s   = pin_s_q[NP-1:sop_array_pkg::SLOT_FB];
    wire logic                            clk_rise = clk_s & ~clk_prev_q;

    //////////////////////////////////////////////////////////////////////////
    // configuration state

    logic [NL-1:0]          cell_q [NT];
    logic                   run_q;
    sop_array_pkg::mode_t   mode_q;
    sop_array_pkg::mc_cfg_t cfg_q;
    logic [NM-1:0]          reg_q;
    logic [NM-1:0]          out_q;
    logic [NM-1:0]          oe_q;
    logic [31:0]            prdata_q;

    //////////////////////////////////////////////////////////////////////////
    // apb decode

    wire logic        setup     = psel & ~penable;
    wire logic        access    = psel & penable;
    wire logic        arr_hit   = paddr[sop_array_pkg::ADDR_W-1:9] == sop_array_pkg::ARR_BASE[sop_array_pkg::ADDR_W-1:9];
    wire logic        ctrl_hit  = paddr == sop_array_pkg::CTRL_ADDR;
    wire logic        cfg_hit   = paddr == sop_array_pkg::CFG_ADDR;
    wire logic        stat_hit  = paddr == sop_array_pkg::STAT_ADDR;
    wire logic        any_hit   = arr_hit | ctrl_hit | cfg_hit | stat_hit;
    wire logic        aligned   = paddr[1:0] == 2'h0;
    wire logic [5:0]  term_sel  = paddr[8:3];
    wire logic        word_hi   = paddr[2];
    wire logic [1:0]  mode_wr   = pwdata[sop_array_pkg::CTRL_MODE_HI:sop_array_pkg::CTRL_MODE_LO];
    wire logic        mode_bad  = mode_wr > 2'(sop_array_pkg::MODE_TRI);
    wire logic        cfg_lock  = run_q & pwrite & (arr_hit | cfg_hit);
    wire logic        bad_req   = ~aligned | ~any_hit | cfg_lock | (pwrite & stat_hit)
                                | (pwrite & ctrl_hit & ~run_q & mode_bad);
    wire logic        wr_ok     = access & pwrite & ~bad_req;
    wire logic        wr_arr    = wr_ok & arr_hit;
    wire logic        wr_ctrl   = wr_ok & ctrl_hit;
    wire logic        wr_cfg    = wr_ok & cfg_hit;

    assign pready  = 1'b1;
    assign pslverr = access & bad_req;
    assign prdata  = prdata_q;

    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = sop_array_pkg::RD_ZERO;
        if (aligned && arr_hit) begin
            if (word_hi) begin
                rd_mux[HW-1:0] = cell_q[term_sel][NL-1:32];
            end else begin
                rd_mux = cell_q[term_sel][31:0];
            end
        end else if (aligned && ctrl_hit) begin
            rd_mux[sop_array_pkg::CTRL_RUN] = run_q;
            rd_mux[sop_array_pkg::CTRL_MODE_HI:sop_array_pkg::CTRL_MODE_LO] = mode_q;
        end else if (aligned && cfg_hit) begin
            rd_mux[sop_array_pkg::CFG_FN_LO +: NM]  = cfg_q.fn;
            rd_mux[sop_array_pkg::CFG_POL_LO +: NM] = cfg_q.act_low;
        end else if (aligned && stat_hit) begin
            rd_mux[sop_array_pkg::STAT_Q_LO +: NM]   = reg_q;
            rd_mux[sop_array_pkg::STAT_PIN_LO +: NM] = out_q;
            rd_mux[sop_array_pkg::STAT_OE_LO +: NM]  = oe_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= sop_array_pkg::RD_ZERO;
        end else if (ce && setup) begin
            prdata_q <= rd_mux;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // configuration writes

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q  <= 1'b0;
            mode_q <= sop_array_pkg::MODE_SIMPLE;
            cfg_q  <= sop_array_pkg::CFG_RST;
        end else if (ce) begin
            if (wr_ctrl) begin
                run_q <= pwdata[sop_array_pkg::CTRL_RUN];
                if (!run_q) begin
                    mode_q <= sop_array_pkg::mode_t'(mode_wr);
                end
            end
            if (wr_cfg) begin
                cfg_q.fn      <= pwdata[sop_array_pkg::CFG_FN_LO +: NM];
                cfg_q.act_low <= pwdata[sop_array_pkg::CFG_POL_LO +: NM];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int t = 0; t < NT; t++) begin
                cell_q[t] <= sop_array_pkg::CELL_RST;
            end
        end else if (ce && wr_arr) begin
            if (word_hi) begin
                cell_q[term_sel][NL-1:32] <= pwdata[HW-1:0];
            end else begin
                cell_q[term_sel][31:0] <= pwdata;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // array inputs and product terms

    wire logic is_reg  = mode_q == sop_array_pkg::MODE_REG;
    wire logic is_tri  = mode_q == sop_array_pkg::MODE_TRI;
    wire logic is_simp = mode_q == sop_array_pkg::MODE_SIMPLE;

    logic [NI-1:0] ain;
    logic [NL-1:0] lines;
    logic [NT-1:0] term;

    assign ain[sop_array_pkg::N_DED-1:0] = din_s;
    // registered mode takes both pins away from the array, their slots read low
    assign ain[sop_array_pkg::SLOT_CLK] = ~is_reg & clk_s;
    assign ain[sop_array_pkg::SLOT_OE]  = ~is_reg & oe_s_b;

    for (genvar k = 0; k < NI; k++) begin : g_line
        assign lines[2*k]   = ain[k];
        assign lines[2*k+1] = ~ain[k];
    end

    for (genvar t = 0; t < NT; t++) begin : g_term
        // a cell left clear forces its line true for this term
        assign term[t] = &(lines | ~cell_q[t]);
    end

    //////////////////////////////////////////////////////////////////////////
    // output macrocells

    logic [NM-1:0] func;
    logic [NM-1:0] mc_reg;
    logic [NM-1:0] out_d;
    logic [NM-1:0] oe_d;

    for (genvar i = 0; i < NM; i++) begin : g_mc
        wire logic [G-1:0] grp    = term[G*i +: G];
        wire logic         outer  = (i == 0) || (i == NM-1);
        wire logic         is_io  = (is_reg & ~cfg_q.fn[i]) | (is_tri & ~outer);
        wire logic         is_ts  = is_tri & outer;
        wire logic         is_out = is_simp & cfg_q.fn[i];
        wire logic         use_en = is_io | is_ts;
        wire logic         sum    = use_en ? |grp[G-1:1] : |grp;

        assign mc_reg[i] = is_reg & cfg_q.fn[i];
        assign func[i]   = sum ^ cfg_q.act_low[i];
        // registered feedback is the register state, all others the pin level
        assign ain[sop_array_pkg::SLOT_FB+i] = mc_reg[i] ? reg_q[i] : io_s[i];
        assign out_d[i] = mc_reg[i] ? ~reg_q[i] : func[i];
        assign oe_d[i]  = run_q & ((mc_reg[i] & ~oe_s_b)
                                 | (use_en & grp[0])
                                 | is_out);
    end

    //////////////////////////////////////////////////////////////////////////
    // macrocell registers and pin drivers

    // register stores the inverted function so the pin shows it true after a clock
    wire logic [NM-1:0] cap = (run_q & clk_rise) ? mc_reg : '0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_q <= '0;
            out_q <= sop_array_pkg::OUT_RST;
            oe_q  <= '0;
        end else if (ce) begin
            reg_q <= (reg_q & ~cap) | (~func & cap);
            out_q <= out_d;
            oe_q  <= oe_d;
        end
    end

    assign io_out = out_q;
    assign io_oe  = oe_q;

endmodule // sop_logic_array

`default_nettype wire

// file: testbench/sop_logic_array_properties.sv
// Purpose: port-level checks for the sum-of-products logic array
// Assumes: ce held high; configuration tracked from accepted apb writes
// Notes:   pin paths run through two synchroniser flops and an output flop
`timescale 1ns/100ps
`default_nettype none
module sop_logic_array_properties (
    input wire logic        clk,      // system clock
    input wire logic        rst_b,    // async reset, active low
    input wire logic        ce,       // clock enable
    input wire logic        psel,     // apb select
    input wire logic        penable,  // apb access phase
    input wire logic        pwrite,   // apb write
    input wire logic [11:0] paddr,    // apb byte address
    input wire logic [31:0] pwdata,   // apb write data
    input wire logic        pslverr,  // apb error
    input wire logic [9:0]  din_pin,  // dedicated inputs
    input wire logic        clk_pin,  // clock-capable pin
    input wire logic        oe_pin_b, // enable-capable pin
    input wire logic [7:0]  io_in,    // macrocell pin level
    input wire logic [7:0]  io_out,   // macrocell drive value
    input wire logic [7:0]  io_oe     // macrocell drive enable
);
    logic       run_q;
    logic [1:0] mode_q;
    logic [7:0] fn_q;
    logic [3:0] age_q;
    wire logic        wr_ok  = psel && penable && pwrite && ce && !pslverr;
    wire logic        ctl_wr = psel && penable && pwrite && paddr == sop_array_pkg::CTRL_ADDR;
    wire logic [19:0] pins_w = {din_pin, clk_pin, oe_pin_b, io_in};
    ////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q <= 1'b0;
            mode_q <= 2'h0;
            fn_q <= 8'h00;
        end else if (wr_ok && ctl_wr) begin
            run_q <= pwdata[0];
            if (!run_q) mode_q <= pwdata[2:1];
        end else if (wr_ok && paddr == sop_array_pkg::CFG_ADDR) begin
            fn_q <= pwdata[7:0];
        end
    end
    // cycles since run was set, saturating
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            age_q <= 4'h0;
        end else begin
            age_q <= !run_q ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    reset_clear_a: assert property ($rose(rst_b) |-> io_out == 8'hFF && io_oe == 8'h00)
        else $error("outputs not at reset level");
    stopped_quiet_a: assert property (!run_q && !$past(run_q) && !$past(run_q, 3) |-> io_oe == 8'h00)
        else $error("pin driven while stopped");
    cfg_locked_a: assert property (psel && penable && pwrite && run_q
        && paddr == sop_array_pkg::CFG_ADDR |-> pslverr) else $error("config write accepted while running");
    mode_limit_a: assert property (ctl_wr && !run_q && pwdata[2:1] == 2'h3 |-> pslverr)
        else $error("fourth mode accepted");
    simple_drive_a: assert property (age_q > 4'h4 && mode_q == 2'h0 |-> io_oe == fn_q)
        else $error("simple mode enables wrong");
    reg_enable_a: assert property (age_q > 4'h5 && mode_q == 2'h1
        |-> (io_oe & fn_q) == (fn_q & {8{!$past(oe_pin_b, 3)}})) else $error("registered enable wrong");
    reg_capture_a: assert property (age_q > 4'h7 && mode_q == 2'h1 && ((io_out ^ $past(io_out)) & fn_q) != 8'h00
        |-> $past(clk_pin, 3) && !$past(clk_pin, 6)) else $error("register changed without clock");
    comb_cause_a: assert property (age_q > 4'h7 && mode_q == 2'h0 && ((io_out ^ $past(io_out)) & fn_q) != 8'h00
        |-> $past(pins_w, 3) != $past(pins_w, 4)) else $error("output changed without input");
    cover property (age_q > 4'h7 && mode_q == 2'h1 && $rose(clk_pin));
    cover property (age_q > 4'h7 && mode_q == 2'h2);
    cover property (pslverr);
endmodule // sop_logic_array_properties

bind sop_logic_array sop_logic_array_properties i_sop_logic_array_properties (.clk, .rst_b, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pslverr, .din_pin, .clk_pin, .oe_pin_b, .io_in, .io_out, .io_oe);
`default_nettype wire

// file: testbench/board_model.sv
// Purpose: board logic around the array pins
// Assumes: pins change only right after a rising clk edge
// Notes:   undriven macrocell pins take the board's own level
`timescale 1ns/100ps
`default_nettype none
module board_model (
    input  wire logic       clk,      // bench clock
    input  wire logic [7:0] io_out,   // macrocell drive value
    input  wire logic [7:0] io_oe,    // macrocell drive enable
    output logic      [9:0] din_pin,  // dedicated inputs
    output logic            clk_pin,  // clock-capable pin
    output logic            oe_pin_b, // enable-capable pin
    output logic      [7:0] io_in     // resolved pin level
);
    logic [7:0] ext;
    assign io_in = (io_oe & io_out) | (~io_oe & ext);
    initial begin
        din_pin = 10'h000;
        clk_pin = 1'b0;
        oe_pin_b = 1'b1;
        ext = 8'h00;
    end
    task automatic set_pins(input logic [9:0] d, input logic g, input logic [7:0] e);
        @(posedge clk);
        din_pin <= d;
        oe_pin_b <= g;
        ext <= e;
    endtask
    // long phases so the synchronisers see each level
    task automatic pulse;
        @(posedge clk);
        clk_pin <= 1'b1;
        repeat (5) @(posedge clk);
        clk_pin <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
endmodule // board_model
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the logic array
// Assumes: ce high but for one freeze test; apb master per the hand-over timing
// Notes:   unused terms are made false by joining a line with its complement
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk;
    logic        rst_b;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [9:0]  din_pin;
    logic        clk_pin;
    logic        oe_pin_b;
    logic [7:0]  io_in;
    logic [7:0]  io_out;
    logic [7:0]  io_oe;
    logic [31:0] rd;
    logic        er;
    int          n_mismatch = 0;
    int          n_checks = 0;
    sop_logic_array i_sop_logic_array (.clk, .rst_b, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .din_pin, .clk_pin, .oe_pin_b, .io_in, .io_out, .io_oe);
    board_model i_board_model (.clk, .io_out, .io_oe, .din_pin, .clk_pin, .oe_pin_b, .io_in);
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [11:0] wa(input int t);
        return 12'(t * 8);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // answer taken at the edge where pready is seen high
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        n_mismatch++;
        complete_run();
    end
    ////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        apb(0, sop_array_pkg::STAT_ADDR, 0); check(rd, 32'h0000_FF00);
        apb(0, wa(5), 0); check(rd, 32'h0000_0000);
        apb(0, 12'h300, 0); check({rd[30:0], er}, 32'h0000_0001);
        apb(1, sop_array_pkg::CTRL_ADDR, 32'h0000_0006); check({31'h0, er}, 32'h0000_0001);
        for (int t = 0; t < 64; t++) apb(1, wa(t), 32'h0000_0003);
        // simple: cell0 din0&~din1, cell1 ~din2, cell3 pin5 level
        apb(1, wa(0), 32'h0000_0009);
        apb(1, wa(8), 32'h0000_0010);
        apb(1, wa(24), 32'h0000_0000);
        apb(1, wa(24) + 12'h004, 32'h0000_0004);
        apb(0, wa(24) + 12'h004, 0); check(rd, 32'h0000_0004);
        apb(1, sop_array_pkg::CFG_ADDR, 32'h0000_020B);
        apb(1, sop_array_pkg::CTRL_ADDR, 32'h0000_0001);
        for (int v = 0; v < 16; v++) begin
            i_board_model.set_pins({v[3], 6'h00, v[2:0]}, 1'b1, {2'h0, v[0] ^ v[3], 5'h00});
            repeat (6) @(posedge clk);
            check({io_oe, io_out & 8'h0B}, {8'h0B, 4'h0, v[0] ^ v[3], 1'b0, !v[2], v[0] & !v[1]});
        end
        apb(1, sop_array_pkg::CFG_ADDR, 32'h0000_0000); check({31'h0, er}, 32'h0000_0001);
        apb(0, sop_array_pkg::CFG_ADDR, 0); check(rd, 32'h0000_020B);
        // registered: cell0 toggles on its own state, cell1 i/o
        apb(1, sop_array_pkg::CTRL_ADDR, 32'h0000_0000);
        apb(1, wa(0), 32'h0100_0000);
        apb(1, wa(8), 32'h0000_0040);
        apb(1, wa(9), 32'h0000_0100);
        apb(1, sop_array_pkg::CFG_ADDR, 32'h0000_0001);
        apb(1, sop_array_pkg::CTRL_ADDR, 32'h0000_0003);
        i_board_model.set_pins(10'h000, 1'b0, 8'h00);
        repeat (6) @(posedge clk);
        check({30'h0, io_oe[0], io_out[0]}, 32'h0000_0003);
        for (int k = 1; k < 4; k++) begin
            i_board_model.pulse();
            check({31'h0, io_out[0]}, {31'h0, !k[0]});
        end
        // a clock pulse while frozen must not be captured
        ce <= 1'b0;
        i_board_model.pulse();
        ce <= 1'b1;
        repeat (6) @(posedge clk);
        check({31'h0, io_out[0]}, 32'h0000_0000);
        apb(0, sop_array_pkg::STAT_ADDR, 0); check({24'h0, rd[7:0]}, 32'h0000_0001);
        for (int v = 0; v < 4; v++) begin
            i_board_model.set_pins({5'h00, v[1:0], 3'h0}, 1'b0, 8'h00);
            repeat (6) @(posedge clk);
            check({30'h0, io_oe[1], io_out[1] & io_oe[1]}, {30'h0, v[0], v[0] & v[1]});
        end
        i_board_model.set_pins(10'h000, 1'b1, 8'h00);
        repeat (6) @(posedge clk);
        check({31'h0, io_oe[0]}, 32'h0000_0000);
        // three-state: cell0 always on, cell7 enabled by din5, value from enable pin
        apb(1, sop_array_pkg::CTRL_ADDR, 32'h0000_0000);
        apb(1, wa(0), 32'h0000_0000);
        apb(1, wa(1), 32'h0000_0001);
        apb(1, wa(56), 32'h0000_0400);
        apb(1, wa(57), 32'h0040_0000);
        apb(1, sop_array_pkg::CTRL_ADDR, 32'h0000_0005);
        for (int v = 0; v < 4; v++) begin
            i_board_model.set_pins({4'h0, v[1], 4'h0, v[0]}, v[0] ^ v[1], 8'h00);
            repeat (6) @(posedge clk);
            check({io_oe[7], io_oe[0], io_out[0], io_out[7] & io_oe[7]}, {v[1], 1'b1, v[0], v[1] & (v[0] ^ v[1])});
        end
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
